/* File: core/gpg_top.v */
// Four-group pin block with APB register file
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "gpg_defines.vh"

module gpg_top (
	// APB clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Pads, group A in the low word
	input wire [127:0] pad_in,
	output wire [127:0] pad_out,
	output wire [127:0] pad_oe,
	output wire [127:0] pull_up_en,
	output wire [127:0] pull_dn_en,
	// Peripheral function side
	input wire [127:0] fn0_out,
	input wire [127:0] fn0_oe,
	input wire [127:0] fn1_out,
	input wire [127:0] fn1_oe,
	output wire [127:0] fn0_in,
	output wire [127:0] fn1_in,
	// Interrupts, one per group
	output wire [3:0] irq
);

// Pull direction per pin; 1 means pull-up
localparam [127:0] PULL_UP_MAP = {`GPG_PULLUP_D, `GPG_PULLUP_C,
	`GPG_PULLUP_B, `GPG_PULLUP_A};

// Plain registers, one word per group
reg [127:0] output_value_reg_r;
reg [127:0] irq_mask_reg_r;
reg [127:0] pull_off_reg_r;
reg [127:0] alt_function_enable_reg_r;
reg [127:0] alt_function_choice_reg_r;
reg [127:0] pin_direction_reg_r;
reg [127:0] trigger_kind_reg_r;
reg [127:0] event_flag_reg_r;

reg [127:0] output_value_reg_nxt;
reg [127:0] irq_mask_reg_nxt;
reg [127:0] pull_off_reg_nxt;
reg [127:0] alt_function_enable_reg_nxt;
reg [127:0] alt_function_choice_reg_nxt;
reg [127:0] pin_direction_reg_nxt;
reg [127:0] trigger_kind_reg_nxt;
reg [127:0] event_flag_reg_nxt;

// Bus side state
reg [31:0] prdata_r;
reg pready_r;
reg pslverr_r;
reg [31:0] rd_val;
reg rd_ok;

// Pad side state
reg [127:0] pad_out_r;
reg [127:0] pad_oe_r;
reg [127:0] pull_up_r;
reg [127:0] pull_dn_r;
reg [127:0] fn0_in_r;
reg [127:0] fn1_in_r;
reg [3:0] irq_r;

wire [127:0] pin_level_reg;
wire [127:0] event_hit;
wire [127:0] irq_en;

wire [1:0] a_grp;
wire [3:0] a_kind;
wire [1:0] a_sub;
wire a_top_ok;
wire acc;
wire wr_acc;
wire rd_acc;

integer g;
integer h;

assign a_grp = paddr[`GPG_GRP_LSB+1:`GPG_GRP_LSB];
assign a_kind = paddr[`GPG_KIND_LSB+3:`GPG_KIND_LSB];
assign a_sub = paddr[`GPG_SUB_LSB+1:`GPG_SUB_LSB];
assign a_top_ok = (paddr[`GPG_AW-1:`GPG_TOP_LSB] == 2'h0);

// Transfer completes in the access cycle that sees pready
assign acc = psel & penable & pready_r;
assign wr_acc = acc & pwrite & ~pslverr_r;
assign rd_acc = acc & ~pwrite & ~pslverr_r;

// Kind field of an offset constant
function [3:0] kind_of;
	input [7:0] off;
	begin
		kind_of = off[7:4];
	end
endfunction

// Companion register action on a plain word
function [31:0] sc_apply;
	input [31:0] cur;
	input [31:0] wd;
	input [1:0] sub;
	begin
		case (sub)
			`GPG_SUB_SET: sc_apply = cur | wd;
			`GPG_SUB_CLR: sc_apply = cur & ~wd;
			default: sc_apply = cur;
		endcase
	end
endfunction

// True for a write to the given kind of group grp
function wr_sel;
	input wr;
	input [1:0] grp_a;
	input [1:0] grp;
	input [3:0] kind_a;
	input [7:0] off;
	begin
		wr_sel = wr && (grp_a == grp) && (kind_a == kind_of(off));
	end
endfunction

// Interrupt mode: function off, select bit on
assign irq_en = ~alt_function_enable_reg_r & alt_function_choice_reg_r;

genvar gi;
generate
	for (gi = 0; gi < `GPG_NGRP; gi = gi + 1) begin : grp
		gpg_sync_detect u_det (
			.pclk(pclk),
			.presetn(presetn),
			.pad_in(pad_in[gi*32 +: 32]),
			.irq_en(irq_en[gi*32 +: 32]),
			.edge_mode(trigger_kind_reg_r[gi*32 +: 32]),
			.polarity(pin_direction_reg_r[gi*32 +: 32]),
			.level(pin_level_reg[gi*32 +: 32]),
			.event_hit(event_hit[gi*32 +: 32])
		);
	end
endgenerate

// Read decode; set/clear companions are write-only and read zero
always @* begin
	rd_val = 32'h00000000;
	rd_ok = a_top_ok;
	case (a_kind)
		kind_of(`GPG_OFF_PIN): rd_val = pin_level_reg[a_grp*32 +: 32];
		kind_of(`GPG_OFF_DATA): rd_val = output_value_reg_r[a_grp*32 +: 32];
		kind_of(`GPG_OFF_MASK): rd_val = irq_mask_reg_r[a_grp*32 +: 32];
		kind_of(`GPG_OFF_POFF): rd_val = pull_off_reg_r[a_grp*32 +: 32];
		kind_of(`GPG_OFF_FUN): rd_val = alt_function_enable_reg_r[a_grp*32 +: 32];
		kind_of(`GPG_OFF_SEL): rd_val = alt_function_choice_reg_r[a_grp*32 +: 32];
		kind_of(`GPG_OFF_DIR): rd_val = pin_direction_reg_r[a_grp*32 +: 32];
		kind_of(`GPG_OFF_TRG): rd_val = trigger_kind_reg_r[a_grp*32 +: 32];
		kind_of(`GPG_OFF_FLAG): rd_val = event_flag_reg_r[a_grp*32 +: 32];
		default: rd_ok = 1'b0;
	endcase
	// Level and flag words have no companions
	if ((a_kind == kind_of(`GPG_OFF_PIN)) || (a_kind == kind_of(`GPG_OFF_FLAG))) begin
		if (a_sub != `GPG_SUB_PLAIN) begin
			rd_ok = 1'b0;
		end
	end
	if (a_sub == 2'h3) begin
		rd_ok = 1'b0;
	end
	if ((a_sub != `GPG_SUB_PLAIN) || !rd_ok) begin
		rd_val = 32'h00000000;
	end
end

// Zero-wait slave: answer decided in setup, shown in access
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready_r <= 1'b0;
		pslverr_r <= 1'b0;
		prdata_r <= 32'h00000000;
	end else begin
		pready_r <= psel & ~penable;
		// Error shows only beside its ready, never lingers
		if (psel && !penable) begin
			pslverr_r <= ~rd_ok;
			prdata_r <= pwrite ? 32'h00000000 : rd_val;
		end else begin
			pslverr_r <= 1'b0;
		end
	end
end

// Next values of the register file
always @* begin
	output_value_reg_nxt = output_value_reg_r;
	irq_mask_reg_nxt = irq_mask_reg_r;
	pull_off_reg_nxt = pull_off_reg_r;
	alt_function_enable_reg_nxt = alt_function_enable_reg_r;
	alt_function_choice_reg_nxt = alt_function_choice_reg_r;
	pin_direction_reg_nxt = pin_direction_reg_r;
	trigger_kind_reg_nxt = trigger_kind_reg_r;
	event_flag_reg_nxt = event_flag_reg_r;
	for (g = 0; g < `GPG_NGRP; g = g + 1) begin
		if (wr_sel(wr_acc, a_grp, g[1:0], a_kind, `GPG_OFF_DATA)) begin
			output_value_reg_nxt[g*32 +: 32] =
				sc_apply(output_value_reg_r[g*32 +: 32], pwdata, a_sub);
		end
		if (wr_sel(wr_acc, a_grp, g[1:0], a_kind, `GPG_OFF_MASK)) begin
			irq_mask_reg_nxt[g*32 +: 32] =
				sc_apply(irq_mask_reg_r[g*32 +: 32], pwdata, a_sub);
		end
		if (wr_sel(wr_acc, a_grp, g[1:0], a_kind, `GPG_OFF_POFF)) begin
			pull_off_reg_nxt[g*32 +: 32] =
				sc_apply(pull_off_reg_r[g*32 +: 32], pwdata, a_sub);
		end
		if (wr_sel(wr_acc, a_grp, g[1:0], a_kind, `GPG_OFF_FUN)) begin
			alt_function_enable_reg_nxt[g*32 +: 32] =
				sc_apply(alt_function_enable_reg_r[g*32 +: 32], pwdata, a_sub);
		end
		if (wr_sel(wr_acc, a_grp, g[1:0], a_kind, `GPG_OFF_SEL)) begin
			alt_function_choice_reg_nxt[g*32 +: 32] =
				sc_apply(alt_function_choice_reg_r[g*32 +: 32], pwdata, a_sub);
		end
		if (wr_sel(wr_acc, a_grp, g[1:0], a_kind, `GPG_OFF_DIR)) begin
			pin_direction_reg_nxt[g*32 +: 32] =
				sc_apply(pin_direction_reg_r[g*32 +: 32], pwdata, a_sub);
		end
		if (wr_sel(wr_acc, a_grp, g[1:0], a_kind, `GPG_OFF_TRG)) begin
			trigger_kind_reg_nxt[g*32 +: 32] =
				sc_apply(trigger_kind_reg_r[g*32 +: 32], pwdata, a_sub);
		end
		// Read clears only what was shown; a new event wins
		if (rd_acc && (a_grp == g[1:0]) && (a_kind == kind_of(`GPG_OFF_FLAG))) begin
			event_flag_reg_nxt[g*32 +: 32] = event_flag_reg_r[g*32 +: 32] & ~prdata_r;
		end
	end
	event_flag_reg_nxt = event_flag_reg_nxt | event_hit;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		output_value_reg_r <= {4{`GPG_RST_CTRL}};
		irq_mask_reg_r <= {4{`GPG_RST_CTRL}};
		pull_off_reg_r <= {4{`GPG_RST_CTRL}};
		alt_function_enable_reg_r <= {4{`GPG_RST_CTRL}};
		alt_function_choice_reg_r <= {4{`GPG_RST_CTRL}};
		pin_direction_reg_r <= {4{`GPG_RST_CTRL}};
		trigger_kind_reg_r <= {4{`GPG_RST_CTRL}};
		event_flag_reg_r <= {4{`GPG_RST_FLAG}};
	end else begin
		output_value_reg_r <= output_value_reg_nxt;
		irq_mask_reg_r <= irq_mask_reg_nxt;
		pull_off_reg_r <= pull_off_reg_nxt;
		alt_function_enable_reg_r <= alt_function_enable_reg_nxt;
		alt_function_choice_reg_r <= alt_function_choice_reg_nxt;
		pin_direction_reg_r <= pin_direction_reg_nxt;
		trigger_kind_reg_r <= trigger_kind_reg_nxt;
		event_flag_reg_r <= event_flag_reg_nxt;
	end
end

// Pad drive; registered so pads never see decode glitches
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pad_out_r <= 128'h0;
		pad_oe_r <= 128'h0;
		pull_up_r <= 128'h0;
		pull_dn_r <= 128'h0;
		fn0_in_r <= 128'h0;
		fn1_in_r <= 128'h0;
	end else begin
		pad_out_r <= (alt_function_enable_reg_r & ~alt_function_choice_reg_r & fn0_out)
			| (alt_function_enable_reg_r & alt_function_choice_reg_r & fn1_out)
			| (~alt_function_enable_reg_r & output_value_reg_r);
		// Interrupt mode forces the pin to input
		pad_oe_r <= (alt_function_enable_reg_r & ~alt_function_choice_reg_r & fn0_oe)
			| (alt_function_enable_reg_r & alt_function_choice_reg_r & fn1_oe)
			| (~alt_function_enable_reg_r & ~alt_function_choice_reg_r
			& pin_direction_reg_r);
		pull_up_r <= ~pull_off_reg_r & PULL_UP_MAP;
		pull_dn_r <= ~pull_off_reg_r & ~PULL_UP_MAP;
		// Peripherals see zero unless their function is routed
		fn0_in_r <= pin_level_reg & alt_function_enable_reg_r
			& ~alt_function_choice_reg_r;
		fn1_in_r <= pin_level_reg & alt_function_enable_reg_r
			& alt_function_choice_reg_r;
	end
end

// One level line per group; lags the flag by one cycle
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		irq_r <= 4'h0;
	end else begin
		for (h = 0; h < `GPG_NGRP; h = h + 1) begin
			irq_r[h] <= |(event_flag_reg_r[h*32 +: 32]
				& ~irq_mask_reg_r[h*32 +: 32]);
		end
	end
end

assign prdata = prdata_r;
assign pready = pready_r;
assign pslverr = pslverr_r;
assign pad_out = pad_out_r;
assign pad_oe = pad_oe_r;
assign pull_up_en = pull_up_r;
assign pull_dn_en = pull_dn_r;
assign fn0_in = fn0_in_r;
assign fn1_in = fn1_in_r;
assign irq = irq_r;

endmodule // gpg_top
`default_nettype wire

/* File: core/gpg_defines.vh */
// Constants for the four-group general-purpose pin block
// Notes on behaviour
// - Each pin: input, output or peripheral function
// - Interrupt trigger: low, high, rising, falling
// - Independent mask bit per pin interrupt
// - Per-pin pull resistor, individually switchable off
// - Four groups A-D, 32 pins each
// - One interrupt output per group
// - Per-group 32-bit registers, bit equals pin
// - Function bit 1 selects peripheral; select picks which
// - Groups A to D pull up
// - Set and clear companions for control registers
`ifndef GPG_DEFINES_VH
`define GPG_DEFINES_VH

`define GPG_NGRP 4
`define GPG_GW 32
`define GPG_AW 12

// Address fields
`define GPG_GRP_LSB 8
`define GPG_KIND_LSB 4
`define GPG_SUB_LSB 2
`define GPG_TOP_LSB 10

// Register kinds, byte offset within a group
`define GPG_OFF_PIN 8'h00
`define GPG_OFF_DATA 8'h10
`define GPG_OFF_MASK 8'h20
`define GPG_OFF_POFF 8'h30
`define GPG_OFF_FUN 8'h40
`define GPG_OFF_SEL 8'h50
`define GPG_OFF_DIR 8'h60
`define GPG_OFF_TRG 8'h70
`define GPG_OFF_FLAG 8'h80

// Companion sub-offsets
`define GPG_SUB_PLAIN 2'h0
`define GPG_SUB_SET 2'h1
`define GPG_SUB_CLR 2'h2

// Reset values
`define GPG_RST_CTRL 32'h00000000
`define GPG_RST_FLAG 32'h00000000
`define GPG_PULLUP_A 32'hffffffff
`define GPG_PULLUP_B 32'hffffffff
`define GPG_PULLUP_C 32'hffffffff
`define GPG_PULLUP_D 32'hffffffff

`endif

/* File: core/gpg_sync_detect.v */
// Pin synchroniser and trigger detector for one group
`timescale 1ns/10ps
`default_nettype none
`include "gpg_defines.vh"

module gpg_sync_detect (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Raw pins
	input wire [31:0] pad_in,
	// Trigger setup
	input wire [31:0] irq_en,
	input wire [31:0] edge_mode,
	input wire [31:0] polarity,
	// Results
	output wire [31:0] level,
	output wire [31:0] event_hit
);

reg [31:0] meta_r;
reg [31:0] level_r;
reg [31:0] prev_r;
reg [31:0] hit_r;
wire [31:0] rise;
wire [31:0] fall;
wire [31:0] edge_hit;
wire [31:0] lvl_hit;

// First stage is read only by the second
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		meta_r <= 32'h00000000;
		level_r <= 32'h00000000;
		prev_r <= 32'h00000000;
	end else begin
		meta_r <= pad_in;
		level_r <= meta_r;
		prev_r <= level_r;
	end
end

assign rise = level_r & ~prev_r;
assign fall = ~level_r & prev_r;
assign edge_hit = (polarity & rise) | (~polarity & fall);
assign lvl_hit = ~(level_r ^ polarity);

// Level sources keep firing while the level holds
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		hit_r <= 32'h00000000;
	end else begin
		hit_r <= irq_en & ((edge_mode & edge_hit) | (~edge_mode & lvl_hit));
	end
end

assign level = level_r;
assign event_hit = hit_r;

endmodule // gpg_sync_detect
`default_nettype wire

/* File: test/gpg_checker.sv */
// Bus and pin checks for the four-group pin block
`timescale 1ns/10ps
`default_nettype none
module gpg_checker (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	// Pins and interrupts
	input wire [127:0] pull_up_en,
	input wire [127:0] pull_dn_en,
	input wire [127:0] fn0_in,
	input wire [127:0] fn1_in,
	input wire [3:0] irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	// Outputs lag the register by one edge, so look two edges on
	sequence s_wr_ones(a);
		psel && penable && pready && pwrite && paddr == a && pwdata == 32'hffffffff;
	endsequence
	property p_rdy;
		s_setup |=> pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_rdy_acc;
		pready |-> psel && penable;
	endproperty
	a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_err_top;
		(s_setup ##0 paddr[11:10] != 2'b00) |=> pslverr;
	endproperty
	a_err_top: assert property (p_err_top) else $error("unmapped not refused");
	property p_dn;
		pull_dn_en[63:0] == 64'h0;
	endproperty
	a_dn: assert property (p_dn) else $error("pull-down on groups A or B");
	property p_pull_off;
		s_wr_ones(12'h034) |=> ##1 pull_up_en[31:0] == 32'h0;
	endproperty
	a_pull_off: assert property (p_pull_off) else $error("pull stays on");
	property p_mask;
		s_wr_ones(12'h024) |=> ##1 !irq[0];
	endproperty
	a_mask: assert property (p_mask) else $error("masked irq high");
	property p_fn;
		(fn0_in & fn1_in) == 128'h0;
	endproperty
	a_fn: assert property (p_fn) else $error("both functions routed");
endmodule // gpg_checker
bind gpg_top gpg_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .pull_up_en, .pull_dn_en, .fn0_in, .fn1_in, .irq);
`default_nettype wire

/* File: test/gpg_partner.sv */
// Board model: loops driven pins back, pulls or wanders otherwise
`timescale 1ns/10ps
`default_nettype none
module gpg_partner (
	// Clock
	input wire logic pclk,
	// Device pins
	input wire logic [127:0] pad_out,
	input wire logic [127:0] pad_oe,
	input wire logic [127:0] pull_up_en,
	// Board drivers
	input wire logic [127:0] ext_val,
	input wire logic [127:0] ext_drv,
	output logic [127:0] pad_in
);
	logic [127:0] flt = 128'h0;
	// Undriven unpulled lines toggle so a stale level never looks valid
	always @(posedge pclk) flt <= ~flt;
	always_comb pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val)
		| (~pad_oe & ~ext_drv & (pull_up_en | flt));
endmodule // gpg_partner
`default_nettype wire

/* File: test/gpg_top_bench.sv */
// Self-checking bench for the four-group pin block
`timescale 1ns/10ps
`default_nettype none
module gpg_top_bench;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd_v;
	logic pready, pslverr, rd_e;
	logic [127:0] pad_in, pad_out, pad_oe, pull_up_en, pull_dn_en, fn0_in, fn1_in;
	logic [127:0] fn0_out = 128'h0, fn0_oe = 128'h0, fn1_out = 128'h0, fn1_oe = 128'h0;
	logic [127:0] ext_val = 128'h0, ext_drv = {128{1'b1}};
	logic [3:0] irq;
	integer n_fail = 0, n_checks = 0, seed = 32'h773b;
	integer m [0:3][1:7] = '{default: 0};
	always #25 pclk = ~pclk;
	gpg_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .pad_in, .pad_out, .pad_oe, .pull_up_en, .pull_dn_en,
		.fn0_out, .fn0_oe, .fn1_out, .fn1_oe, .fn0_in, .fn1_in, .irq);
	gpg_partner u_brd (.pclk, .pad_out, .pad_oe, .pull_up_en, .ext_val, .ext_drv, .pad_in);
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk_word(input string what, input logic [31:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask
	function automatic logic [31:0] mix(input logic [31:0] oe, o, e);
		return (oe & o) | (~oe & e);
	endfunction
	// Request held until ready is seen at a rising edge; only the watchdog ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_v = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic setclr(input integer g, k, input logic [31:0] s, c);
		apb(1'b1, 12'(g * 256 + k * 16 + 4), s);
		apb(1'b1, 12'(g * 256 + k * 16 + 8), c);
		m[g][k] = (m[g][k] | s) & ~c;
	endtask
	task automatic rdm(input integer g, k);
		apb(1'b0, 12'(g * 256 + k * 16), 32'h0);
		chk_word("register", m[g][k], rd_v);
		chk_bit("slave error", 1'b0, rd_e);
	endtask
	initial begin
		integer g, k, i;
		logic [11:0] bad [0:4];
		logic [31:0] v;
		bad = '{12'h400, 12'h090, 12'h02c, 12'h004, 12'h084};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		fn0_out <= {4{$random(seed)}};
		fn0_oe <= {4{$random(seed)}};
		fn1_out <= {4{$random(seed)}};
		fn1_oe <= {4{$random(seed)}};
		ext_val[63:32] <= $random(seed);
		for (g = 0; g < 4; g++) begin
			for (k = 1; k < 8; k++) begin
				rdm(g, k);
				setclr(g, k, $random(seed), $random(seed));
				apb(1'b1, 12'(g * 256 + k * 16), 32'hffffffff);
				rdm(g, k);
				setclr(g, k, 32'h0, 32'hffffffff);
			end
			apb(1'b0, 12'(g * 256 + 128), 32'h0);
		end
		for (i = 0; i < 5; i++) begin
			apb(1'b0, bad[i], 32'h0);
			chk_bit("slave error", 1'b1, rd_e);
		end
		v = $random(seed);
		setclr(2, 1, v, ~v);
		setclr(2, 6, 32'hffffffff, 32'h0);
		repeat (3) @(negedge pclk);
		chk_word("pad enable", 32'hffffffff, pad_oe[95:64]);
		chk_word("pad value", v, pad_out[95:64]);
		apb(1'b0, 12'h200, 32'h0);
		chk_word("pin level", v, rd_v);
		setclr(1, 4, 32'hffffffff, 32'h0);
		// Pad register, two sync stages, then the routed input register
		repeat (6) @(negedge pclk);
		chk_word("fn0 in", mix(fn0_oe[63:32], fn0_out[63:32], ext_val[63:32]), fn0_in[63:32]);
		setclr(1, 5, 32'hffffffff, 32'h0);
		repeat (6) @(negedge pclk);
		chk_word("fn1 in", mix(fn1_oe[63:32], fn1_out[63:32], ext_val[63:32]), fn1_in[63:32]);
		chk_word("fn0 in", 32'h0, fn0_in[63:32]);
		@(posedge pclk);
		ext_drv[31:0] <= 32'h0;
		repeat (4) @(negedge pclk);
		apb(1'b0, 12'h000, 32'h0);
		chk_word("pulled pin", 32'hffffffff, rd_v);
		chk_word("pull-up", 32'hffffffff, pull_up_en[63:32]);
		setclr(0, 3, 32'hffffffff, 32'h0);
		repeat (2) @(negedge pclk);
		chk_word("pull-up", 32'h0, pull_up_en[31:0]);
		setclr(0, 3, 32'h0, 32'hffffffff);
		ext_drv[31:0] <= 32'hffffffff;
		setclr(0, 5, 32'hffffffff, 32'h0);
		// Low, high, falling, rising: idle level first, then the active one
		for (i = 0; i < 4; i++) begin
			setclr(0, 7, {32{i[1]}}, {32{~i[1]}});
			setclr(0, 6, {32{i[0]}}, {32{~i[0]}});
			ext_val[31:0] <= {32{~i[0]}};
			repeat (8) @(negedge pclk);
			apb(1'b0, 12'h080, 32'h0);
			apb(1'b0, 12'h080, 32'h0);
			chk_word("idle flag", 32'h0, rd_v);
			ext_val[31:0] <= {32{i[0]}};
			repeat (8) @(negedge pclk);
			chk_bit("irq", 1'b1, irq[0]);
			chk_bit("other irqs", 1'b0, |irq[3:1]);
			apb(1'b0, 12'h080, 32'h0);
			chk_word("flag", 32'hffffffff, rd_v);
			repeat (4) @(negedge pclk);
			chk_bit("irq after read", ~i[1], irq[0]);
		end
		setclr(0, 7, 32'h0, 32'hffffffff);
		setclr(0, 2, 32'hffffffff, 32'h0);
		repeat (3) @(negedge pclk);
		chk_bit("masked irq", 1'b0, irq[0]);
		apb(1'b0, 12'h080, 32'h0);
		chk_word("masked flag", 32'hffffffff, rd_v);
		setclr(0, 2, 32'h0, 32'h80);
		repeat (3) @(negedge pclk);
		chk_bit("one unmasked", 1'b1, irq[0]);
		rdm(0, 2);
		stop_test;
	end
	initial begin
		#1000000;
		n_fail++;
		stop_test;
	end
endmodule // gpg_top_bench
`default_nettype wire
